// >>> pkg/tlbreg_pkg.sv
// Purpose: constants for the translation buffer control registers
// Assumes: AHB-Lite register access, 32-bit words
// Notes: register indices are word numbers; byte address is index * 4
`default_nettype none
package tlbreg_pkg;
    localparam logic [2:0] IDX_ENTRY_SELECTOR = 3'h0;
    localparam logic [2:0] IDX_REPLACEMENT_POINTER = 3'h1;
    localparam logic [2:0] IDX_EVEN_PAGE_FRAME = 3'h2;
    localparam logic [2:0] IDX_ODD_PAGE_FRAME = 3'h3;
    localparam logic [2:0] IDX_PAGE_SIZE_MASK = 3'h5;
    localparam logic [2:0] IDX_LOCKED_BOUNDARY = 3'h6;
    localparam logic [2:0] IDX_OPERATION = 3'h7;
    localparam int ADDR_LSB = 2;
    localparam int PROBE_MISS_BIT = 31;
    localparam logic [4:0] TOP_ENTRY = 5'h1F;
    localparam logic [5:0] POINTER_RESET = 6'h1F;
    localparam logic [5:0] BOUNDARY_RESET = 6'h00;
    localparam logic [5:0] FIELD6_RESET = 6'h00;
    localparam logic [25:0] FRAME_RESET = 26'h0000000;
    localparam logic [11:0] MASK_RESET = 12'h000;
    localparam int MASK_LSB = 13;
    localparam int MASK_MSB = 24;
    localparam int FRAME_MSB = 25;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] OP_PROBE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_WRITE_INDEXED = 2'h2;
    localparam logic [1:0] OP_WRITE_RANDOM = 2'h3;
endpackage
`default_nettype wire

// >>> verilog/tlbreg_top.sv
// Purpose: translation buffer entry selector, replacement pointer,
//          locked boundary, page frame and page mask registers
// Assumes: pipeline strobes are synchronous to core_clk_i
// Notes: the buffer array itself lives outside; this block steers it
`default_nettype none
// Contract
// - read/write selector holds six-bit entry field
// - selector top bit flags latest probe miss
// - selector names entry for read/indexed write
// - only selector bits 4:0 steer operations
// - reserved bits written zero, read zero
// - read-only pointer; pointer, boundary use 4:0
// - pointer decrements per instruction, within bounds
// - random write uses current pointer value
// - cold reset loads pointer with 31
// - boundary write forces pointer to 31
// - even and odd page frame registers
// - read/write page mask, buffer source/destination
// - stored mask holds only address bits 24:13
// - random write never hits locked entries, except one issued in a boundary write cycle
// - boundary entry itself is randomly replaceable
// - cold reset clears boundary to zero
module tlbreg_top
    import tlbreg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // pipeline side
    input wire logic instr_retire_i,
    input wire logic op_valid_i,
    input wire logic [1:0] op_kind_i,
    input wire logic probe_hit_i,
    input wire logic [4:0] probe_entry_i,
    input wire logic [25:0] read_even_frame_i,
    input wire logic [25:0] read_odd_frame_i,
    input wire logic [11:0] read_mask_i,
    // buffer array side
    output logic buf_write_o,
    output logic [4:0] buf_entry_o,
    output logic [25:0] buf_even_frame_o,
    output logic [25:0] buf_odd_frame_o,
    output logic [11:0] buf_mask_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic probe_miss;
    logic [5:0] entry_field;
    logic [5:0] pointer;
    logic [5:0] boundary;
    logic [25:0] even_frame;
    logic [25:0] odd_frame;
    logic [11:0] mask;

    logic ph_write;
    logic ph_read;
    logic [2:0] ph_index;
    logic [31:0] next_rdata;
    logic bus_ok;
    logic wr_boundary;
    logic wr_op;
    logic [1:0] next_op;
    logic op_fire;
    logic [2:0] rd_index;

    typedef enum logic [1:0] {
        TLBREG_IDLE,
        TLBREG_DATA
    } tlbreg_phase_t;
    tlbreg_phase_t phase;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    assign bus_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ)
                    && (hsize_i == HSIZE_WORD);
    assign rd_index = haddr_i[ADDR_LSB+2:ADDR_LSB];

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase <= TLBREG_IDLE;
            ph_write <= 1'b0;
            ph_read <= 1'b0;
            ph_index <= 3'h0;
        end else begin
            case (phase)
                TLBREG_IDLE,
                TLBREG_DATA: begin
                    phase <= bus_ok ? TLBREG_DATA : TLBREG_IDLE;
                    ph_write <= bus_ok && hwrite_i;
                    ph_read <= bus_ok && !hwrite_i;
                    ph_index <= haddr_i[ADDR_LSB+2:ADDR_LSB];
                end
                default: begin
                    phase <= TLBREG_IDLE;
                    ph_write <= 1'b0;
                    ph_read <= 1'b0;
                end
            endcase
        end
    end

    // zero wait states; reads come from registers in the address phase
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // bits that software can write and read back, per register index;
    // everything outside them is reserved and reads zero, except the read-only pointer bits 5:0
    function automatic logic [31:0] sw_bits(input logic [2:0] idx);
        case (idx)
            IDX_ENTRY_SELECTOR: sw_bits = 32'h8000003F;
            IDX_EVEN_PAGE_FRAME,
            IDX_ODD_PAGE_FRAME: sw_bits = 32'h03FFFFFF;
            IDX_PAGE_SIZE_MASK: sw_bits = 32'h01FFE000;
            IDX_LOCKED_BOUNDARY: sw_bits = 32'h0000003F;
            default: sw_bits = 32'h00000000;
        endcase
    endfunction

    always_comb begin
        next_rdata = 32'h00000000;
        case (haddr_i[ADDR_LSB+2:ADDR_LSB])
            IDX_ENTRY_SELECTOR: begin
                next_rdata[PROBE_MISS_BIT] = probe_miss;
                next_rdata[5:0] = entry_field;
            end
            IDX_REPLACEMENT_POINTER: next_rdata[5:0] = pointer;
            IDX_EVEN_PAGE_FRAME: next_rdata[FRAME_MSB:0] = even_frame;
            IDX_ODD_PAGE_FRAME: next_rdata[FRAME_MSB:0] = odd_frame;
            IDX_PAGE_SIZE_MASK: next_rdata[MASK_MSB:MASK_LSB] = mask;
            IDX_LOCKED_BOUNDARY: next_rdata[5:0] = boundary;
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h00000000;
        end else if (bus_ok && !hwrite_i) begin
            // a read may follow a write at once; forward the written word
            // so the read is not stale. a probe or buffer read landing in
            // that same cycle is not reflected in the forwarded value
            if (ph_write && ph_index == rd_index
                && sw_bits(rd_index) != 32'h00000000) begin
                hrdata_o <= hwdata_i & sw_bits(rd_index);
            end else if (wr_boundary
                         && rd_index == IDX_REPLACEMENT_POINTER) begin
                hrdata_o <= {26'h0000000, POINTER_RESET};
            end else begin
                hrdata_o <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // software writes and pipeline operations
    // ------------------------------------------------------------
    assign wr_boundary = ph_write && (ph_index == IDX_LOCKED_BOUNDARY);
    assign wr_op = ph_write && (ph_index == IDX_OPERATION);
    assign op_fire = op_valid_i || wr_op;
    assign next_op = wr_op ? hwdata_i[1:0] : op_kind_i;

    // selector; probe result wins over a software write
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            probe_miss <= 1'b0;
            entry_field <= FIELD6_RESET;
        end else if (op_fire && next_op == OP_PROBE) begin
            probe_miss <= !probe_hit_i;
            if (probe_hit_i) begin
                entry_field <= {1'b0, probe_entry_i};
            end
        end else if (ph_write && ph_index == IDX_ENTRY_SELECTOR) begin
            probe_miss <= hwdata_i[PROBE_MISS_BIT];
            entry_field <= hwdata_i[5:0];
        end
    end

    // holding registers; buffer read loads them
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            even_frame <= FRAME_RESET;
            odd_frame <= FRAME_RESET;
            mask <= MASK_RESET;
        end else if (op_fire && next_op == OP_READ) begin
            even_frame <= read_even_frame_i;
            odd_frame <= read_odd_frame_i;
            mask <= read_mask_i;
        end else if (ph_write) begin
            if (ph_index == IDX_EVEN_PAGE_FRAME) begin
                even_frame <= hwdata_i[FRAME_MSB:0];
            end
            if (ph_index == IDX_ODD_PAGE_FRAME) begin
                odd_frame <= hwdata_i[FRAME_MSB:0];
            end
            if (ph_index == IDX_PAGE_SIZE_MASK) begin
                mask <= hwdata_i[MASK_MSB:MASK_LSB];
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            boundary <= BOUNDARY_RESET;
        end else if (wr_boundary) begin
            boundary <= hwdata_i[5:0];
        end
    end

    // ------------------------------------------------------------
    // replacement pointer
    // ------------------------------------------------------------
    // bit 5 of the pointer is never set by hardware; it reads back 0
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pointer <= POINTER_RESET;
        end else if (wr_boundary) begin
            pointer <= POINTER_RESET;
        end else if (instr_retire_i) begin
            // boundary entry stays in the random region
            if (pointer[4:0] <= boundary[4:0]) begin
                pointer <= POINTER_RESET;
            end else begin
                pointer <= pointer - 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // buffer array drive
    // ------------------------------------------------------------
    // pointer never rests below the boundary, so random writes land in the locked region
    // only when issued in the cycle of a boundary write; indexed writes may go anywhere
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            buf_write_o <= 1'b0;
            buf_entry_o <= 5'h00;
            buf_even_frame_o <= FRAME_RESET;
            buf_odd_frame_o <= FRAME_RESET;
            buf_mask_o <= MASK_RESET;
        end else begin
            buf_write_o <= op_fire && (next_op == OP_WRITE_INDEXED
                           || next_op == OP_WRITE_RANDOM);
            if (op_fire && next_op == OP_WRITE_RANDOM) begin
                buf_entry_o <= pointer[4:0];
            end else begin
                buf_entry_o <= entry_field[4:0];
            end
            buf_even_frame_o <= even_frame;
            buf_odd_frame_o <= odd_frame;
            buf_mask_o <= mask;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ptr_bounds;
        @(posedge core_clk_i) disable iff (reset_i)
        pointer[4:0] >= boundary[4:0] || pointer == POINTER_RESET;
    endproperty
    a_ptr_bounds: assert property (p_ptr_bounds)
        else $error("pointer below boundary");

    property p_wrap;
        @(posedge core_clk_i) disable iff (reset_i)
        (instr_retire_i && !wr_boundary
         && pointer[4:0] <= boundary[4:0]) |=> pointer == 6'h1F;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("pointer did not reload");

    property p_dec;
        @(posedge core_clk_i) disable iff (reset_i)
        (instr_retire_i && !wr_boundary && pointer[4:0] > boundary[4:0])
        |=> pointer == $past(pointer) - 6'h01;
    endproperty
    a_dec: assert property (p_dec)
        else $error("pointer did not decrement");

    property p_bwr;
        @(posedge core_clk_i) disable iff (reset_i)
        wr_boundary |=> pointer == 6'h1F && boundary == $past(hwdata_i[5:0]);
    endproperty
    a_bwr: assert property (p_bwr)
        else $error("boundary write did not reset pointer");

    property p_miss;
        @(posedge core_clk_i) disable iff (reset_i)
        (op_fire && next_op == OP_PROBE) |=> probe_miss == !$past(probe_hit_i);
    endproperty
    a_miss: assert property (p_miss)
        else $error("probe flag wrong");

    property p_rand;
        @(posedge core_clk_i) disable iff (reset_i)
        (op_fire && next_op == OP_WRITE_RANDOM)
        |=> buf_write_o && buf_entry_o == $past(pointer[4:0]);
    endproperty
    a_rand: assert property (p_rand)
        else $error("random write entry wrong");

    property p_idx;
        @(posedge core_clk_i) disable iff (reset_i)
        (op_fire && next_op == OP_WRITE_INDEXED)
        |=> buf_write_o && buf_entry_o == $past(entry_field[4:0]);
    endproperty
    a_idx: assert property (p_idx)
        else $error("indexed write entry wrong");

    property p_lock;
        @(posedge core_clk_i) disable iff (reset_i)
        (op_fire && next_op == OP_WRITE_RANDOM)
        |=> buf_entry_o >= $past(boundary[4:0]) || buf_entry_o == 5'h1F;
    endproperty
    a_lock: assert property (p_lock)
        else $error("random write into locked region");

    property p_rsvd;
        @(posedge core_clk_i) disable iff (reset_i)
        ph_read && $past(haddr_i[4:2]) == IDX_REPLACEMENT_POINTER
        |-> hrdata_o[31:6] == 26'h0000000;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits not zero");

    property p_reset_vals;
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> pointer == POINTER_RESET
                           && boundary == BOUNDARY_RESET;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("pointer or boundary wrong after reset");

    property p_hit_entry;
        @(posedge core_clk_i) disable iff (reset_i)
        (op_fire && next_op == OP_PROBE && probe_hit_i)
        |=> entry_field == {1'b0, $past(probe_entry_i)};
    endproperty
    a_hit_entry: assert property (p_hit_entry)
        else $error("probe hit did not load selector");

    property p_hold_load;
        @(posedge core_clk_i) disable iff (reset_i)
        (op_fire && next_op == OP_READ)
        |=> even_frame == $past(read_even_frame_i)
            && odd_frame == $past(read_odd_frame_i)
            && mask == $past(read_mask_i);
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("buffer read did not load holding registers");

    property p_rsvd_all;
        @(posedge core_clk_i) disable iff (reset_i)
        ph_read |-> (hrdata_o & ~(sw_bits(ph_index) | 32'h0000003F))
                    == 32'h00000000;
    endproperty
    a_rsvd_all: assert property (p_rsvd_all)
        else $error("reserved read bits not zero");

endmodule // tlbreg_top
`default_nettype wire

// >>> sim/tlbreg_pipe_model.sv
// Purpose: pipeline model issuing buffer operations
// Assumes: pulses launched just after a rising edge
// Notes: idle data lines show the inverse of their last value
`default_nettype none
module tlbreg_pipe_model (
    input wire logic core_clk_i,
    output logic instr_retire_o,
    output logic op_valid_o,
    output logic [1:0] op_kind_o,
    output logic probe_hit_o,
    output logic [4:0] probe_entry_o,
    output logic [25:0] even_o,
    output logic [25:0] odd_o,
    output logic [11:0] mask_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        instr_retire_o = 1'b0;
        op_valid_o = 1'b0;
        op_kind_o = 2'h0;
        probe_hit_o = 1'b0;
        probe_entry_o = 5'h00;
        even_o = 26'h0000000;
        odd_o = 26'h0000000;
        mask_o = 12'h000;
    end
    // one high cycle per executed instruction, back to back
    task automatic retire(input int n);
        @(posedge core_clk_i);
        instr_retire_o <= 1'b1;
        repeat (n) @(posedge core_clk_i);
        instr_retire_o <= 1'b0;
    endtask
    task automatic issue(input logic [1:0] k, input logic h,
                         input logic [4:0] e, input logic [25:0] fe,
                         input logic [25:0] fo, input logic [11:0] m);
        @(posedge core_clk_i);
        op_valid_o <= 1'b1;
        op_kind_o <= k;
        probe_hit_o <= h;
        probe_entry_o <= e;
        even_o <= fe;
        odd_o <= fo;
        mask_o <= m;
        @(posedge core_clk_i);
        op_valid_o <= 1'b0;
        probe_hit_o <= ~h;
        probe_entry_o <= ~e;
        even_o <= ~fe;
        odd_o <= ~fo;
        mask_o <= ~m;
        // settle time so a following read sees the update
        @(posedge core_clk_i);
    endtask
endmodule // tlbreg_pipe_model
`default_nettype wire

// >>> sim/test_tlbreg_top.sv
// Purpose: self-checking bench for the buffer control registers
// Assumes: zero-wait ahb-lite slave, one pipeline model
// Notes: expectations come from a small pointer model
`default_nettype none
module test_tlbreg_top import tlbreg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rd_phase = 1'b0;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, buf_write_o, rt, ov, ph;
    logic [4:0] buf_entry_o, pe;
    logic [1:0] ok;
    logic [25:0] fe, fo, bef, bof;
    logic [11:0] fm, bmk;
    logic [31:0] exp_q[$], msk_q[$];
    logic [4:0] ent_q[$];
    logic [63:0] frm_q[$], frm_m, fx;
    int mismatches = 0;
    int tests_run = 0;
    int seed = 75;
    int ptr_m = 31;
    int bnd_m = 0;
    always #5 core_clk_i = ~core_clk_i;
    tlbreg_top i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .instr_retire_i(rt), .op_valid_i(ov), .op_kind_i(ok),
        .probe_hit_i(ph), .probe_entry_i(pe), .read_even_frame_i(fe),
        .read_odd_frame_i(fo), .read_mask_i(fm),
        .buf_write_o(buf_write_o), .buf_entry_o(buf_entry_o),
        .buf_even_frame_o(bef), .buf_odd_frame_o(bof), .buf_mask_o(bmk));
    tlbreg_pipe_model i_pipe (.core_clk_i(core_clk_i),
        .instr_retire_o(rt), .op_valid_o(ov), .op_kind_o(ok),
        .probe_hit_o(ph), .probe_entry_o(pe), .even_o(fe), .odd_o(fo),
        .mask_o(fm));
    // ----------------------------------------
    // bus master and checking
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 64);
        if (hreadyout_o !== 1'b1) begin
            check("hreadyout_o", 32'h0, 32'h1);
            wrap_up();
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] idx,
                       input logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        haddr <= {27'h0, idx, 2'h0};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !w;
        wait_rdy();
        rd_phase <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] idx, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, idx, 32'h0);
    endtask
    // notes the entry and holding values a buffer write must carry
    task automatic wr_op(input logic [1:0] k, input logic [4:0] e);
        ent_q.push_back(e);
        frm_q.push_back(frm_m);
        i_pipe.issue(k, 1'b0, 5'h0, 26'h0, 26'h0, 12'h0);
    endtask
    task automatic retire(input int n);
        repeat (n) ptr_m = (ptr_m <= bnd_m[4:0]) ? 31 : ptr_m - 1;
        if (n > 0) i_pipe.retire(n);
    endtask
    task automatic wrap_up();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        if (rd_phase && hreadyout_o === 1'b1) begin
            check("hresp_o", {31'h0, hresp_o}, 32'h0);
            check("hrdata_o", hrdata_o & msk_q.pop_front(),
                  exp_q.pop_front());
        end
        if (buf_write_o === 1'b1) begin
            if (ent_q.size() == 0) begin
                check("buf_write_o", 32'h1, 32'h0);
            end else begin
                fx = frm_q.pop_front();
                check("buf_entry_o", {27'h0, buf_entry_o},
                      {27'h0, ent_q.pop_front()});
                check("buf_even_frame_o", 32'(bef), 32'(fx[63:38]));
                check("buf_odd_frame_o", 32'(bof), 32'(fx[37:12]));
                check("buf_mask_o", 32'(bmk), 32'(fx[11:0]));
            end
        end
    end
    initial begin
        logic [31:0] d;
        logic [31:0] wm [7];
        wm = '{32'h8000003F, 32'h0, 32'h03FFFFFF, 32'h03FFFFFF, 32'h0,
               32'h01FFE000, 32'h0000003F};
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        for (int i = 0; i < 7; i++) begin
            rd(3'(i), (i == 1) ? 32'h1F : 32'h0, '1);
        end
        $display("done reset values");
        for (int i = 0; i < 7; i++) begin
            d = $random(seed);
            if (i == 0) d = d & 32'h1F;
            if (i == 5)
                d = ((32'h1 << (2 * (d % 7))) - 1) << MASK_LSB;
            d = d & wm[i];
            bus(1'b1, 3'(i), d);
            if (i == 2) frm_m[63:38] = d[25:0];
            if (i == 3) frm_m[37:12] = d[25:0];
            if (i == 5) frm_m[11:0] = d[MASK_MSB:MASK_LSB];
            if (i == 6) bnd_m = d[5:0];
            rd(3'(i), (i == 1) ? 32'h1F : d, '1);
        end
        $display("done register access");
        retire(5);
        rd(3'h1, ptr_m, '1);
        bus(1'b1, 3'h6, 32'h23);
        bnd_m = 32'h23;
        ptr_m = 31;
        rd(3'h6, 32'h23, '1);
        rd(3'h1, 32'h1F, '1);
        retire(40);
        rd(3'h1, ptr_m, '1);
        $display("done pointer");
        retire(ptr_m - 3);
        wr_op(OP_WRITE_RANDOM, 5'h03);
        retire(1);
        wr_op(OP_WRITE_RANDOM, TOP_ENTRY);
        bus(1'b1, 3'h0, 32'h25);
        rd(3'h0, 32'h25, '1);
        wr_op(OP_WRITE_INDEXED, 5'h05);
        bus(1'b1, 3'h0, 32'h01);
        wr_op(OP_WRITE_INDEXED, 5'h01);
        $display("done buffer writes");
        i_pipe.issue(OP_PROBE, 1'b1, 5'h07, 26'h0, 26'h0, 12'h0);
        rd(3'h0, 32'h07, '1);
        i_pipe.issue(OP_PROBE, 1'b0, 5'h09, 26'h0, 26'h0, 12'h0);
        rd(3'h0, 32'h80000000, 32'h80000000);
        $display("done probe");
        d = $random(seed);
        i_pipe.issue(OP_READ, 1'b0, 5'h0, d[25:0], ~d[25:0], 12'h03F);
        frm_m = {d[25:0], ~d[25:0], 12'h03F};
        rd(3'h2, {6'h0, d[25:0]}, '1);
        rd(3'h3, {6'h0, ~d[25:0]}, '1);
        rd(3'h5, 32'h0007E000, '1);
        $display("done buffer read");
        ent_q.push_back(5'h07);
        frm_q.push_back(frm_m);
        bus(1'b1, IDX_OPERATION, {30'h0, OP_WRITE_INDEXED});
        rd(IDX_OPERATION, 32'h0, '1);
        $display("done operation register");
        repeat (3) @(posedge core_clk_i);
        wrap_up();
    end
endmodule // test_tlbreg_top
`default_nettype wire
